//--- dv/ascd_decoder_chk.sv
// Port-level assertions of the serial command decoder.
// Assumes binding to ascd_decoder; sees its ports only.
`default_nettype none
module ascd_decoder_chk (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [7:0] o_conversion_request,
    input wire logic [7:0] o_setup_config,
    input wire logic [7:0] o_averaging_config,
    input wire logic [7:0] o_unipolar_pair,
    input wire logic [7:0] o_bipolar_pair,
    input wire logic o_scan_start,
    input wire logic [3:0] o_scan_first_chan,
    input wire logic [3:0] o_scan_last_chan,
    input wire logic [4:0] o_scan_result_count,
    input wire logic o_scan_temp_first,
    input wire logic o_scan_averaging,
    input wire logic [15:0] o_chan_skip,
    input wire logic [7:0] o_pair_twos_comp,
    input wire logic o_fifo_clear
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    reset_defaults_a: assert property (disable iff (1'b0) !i_rstn |=>
        o_setup_config == 8'h20 && (o_conversion_request | o_averaging_config | o_unipolar_pair | o_bipolar_pair) == 8'h00
        && !o_scan_start) else $error("Registers not at reset values");
    scan_pulse_a: assert property (o_scan_start |=> !o_scan_start) else $error("Scan start too long");
    clear_pulse_a: assert property (o_fifo_clear |=> !o_fifo_clear) else $error("Clear pulse too long");
    repeat_plan_a: assert property (o_scan_start && o_conversion_request[2:1] == 2'h2 |->
        o_scan_first_chan == o_conversion_request[6:3] && o_scan_last_chan == o_conversion_request[6:3]
        && o_scan_result_count == (o_chan_skip[o_conversion_request[6:3]] ? 5'h00
        : (5'h01 + o_averaging_config[1:0]) * 5'h04)) else $error("Bad repeat plan");
    single_plan_a: assert property (o_scan_start && o_conversion_request[2:1] == 2'h3 |->
        o_scan_first_chan == o_conversion_request[6:3] && o_scan_last_chan == o_conversion_request[6:3]
        && o_scan_result_count == (o_chan_skip[o_conversion_request[6:3]] ? 5'h00 : 5'h01))
        else $error("Bad single plan");
    range_low_a: assert property (o_scan_start && o_conversion_request[2:1] == 2'h0 |->
        o_scan_first_chan == 4'h0 && o_scan_last_chan == o_conversion_request[6:3]) else $error("Bad range plan");
    range_high_a: assert property (o_scan_start && o_conversion_request[2:1] == 2'h1 |->
        o_scan_first_chan == o_conversion_request[6:3] && o_scan_last_chan == 4'hF) else $error("Bad upper range plan");
    temp_first_a: assert property (o_scan_start |-> o_scan_temp_first == o_conversion_request[0])
        else $error("Bad temperature flag");
    avg_gate_a: assert property (o_scan_start |->
        o_scan_averaging == (o_averaging_config[4] && o_setup_config[5:4] != 2'h3)) else $error("Bad averaging flag");
    pair_format_a: assert property ($stable(o_bipolar_pair) && $stable(o_unipolar_pair) |->
        o_pair_twos_comp == (o_bipolar_pair & ~o_unipolar_pair)) else $error("Bad pair format");
    skip_map_a: assert property ($stable(o_setup_config) && $stable(o_unipolar_pair[0]) &&
        $stable(o_bipolar_pair[0]) && !o_unipolar_pair[0] && !o_bipolar_pair[0] |->
        o_chan_skip[15] == !o_setup_config[5] && o_chan_skip[14] == (o_setup_config[3:2] == 2'h3))
        else $error("Bad skip map");
endmodule
bind ascd_decoder ascd_decoder_chk u_chk (.i_clk, .i_rstn, .o_conversion_request, .o_setup_config,
    .o_averaging_config, .o_unipolar_pair, .o_bipolar_pair, .o_scan_start, .o_scan_first_chan, .o_scan_last_chan,
    .o_scan_result_count, .o_scan_temp_first, .o_scan_averaging, .o_chan_skip, .o_pair_twos_comp, .o_fifo_clear);
`default_nettype wire

//--- dv/ascd_spi_host.sv
// Serial master model: drives chip select, serial clock and data in.
// Assumes a bench that calls put_byte; serial clock idles low outside frames.
`default_nettype none
module ascd_spi_host (
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_din
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HALF_NS = 400;
    localparam int SKEW_NS = 20;
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_din = 1'b0;
    end
    // Keeps select low across bytes so a pair byte rides in one frame
    task automatic put_byte(input logic [7:0] b, input bit end_frame);
        // Keeps every pin change off the system clock edge
        #SKEW_NS;
        o_cs_n = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            o_din = b[i];
            #HALF_NS o_sclk = 1'b1;
            #HALF_NS o_sclk = 1'b0;
        end
        if (end_frame) begin
            #HALF_NS o_cs_n = 1'b1;
            // Released line shows no stale bit
            o_din = ~o_din;
        end
    endtask
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// Directed testbench of the serial command decoder.
// Assumes the host model owns the serial pins; bench owns reset and start pin.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk, i_rstn, i_conv_start_n;
    wire i_sclk, i_cs_n, i_din, o_scan_start, o_scan_temp_first, o_scan_averaging, o_fifo_clear;
    wire [7:0] o_conversion_request, o_setup_config, o_averaging_config, o_unipolar_pair, o_bipolar_pair;
    wire [7:0] o_pair_twos_comp;
    wire [3:0] o_scan_first_chan, o_scan_last_chan;
    wire [4:0] o_scan_result_count;
    wire [15:0] o_chan_skip;
    int n_errors = 0, num_checks = 0, n_scan = 0, n_clr = 0;
    ascd_spi_host u_host (.o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_din(i_din));
    ascd_decoder DUT (.i_clk, .i_rstn, .i_sclk, .i_cs_n, .i_din, .i_conv_start_n, .o_conversion_request,
        .o_setup_config, .o_averaging_config, .o_unipolar_pair, .o_bipolar_pair, .o_scan_start, .o_scan_first_chan,
        .o_scan_last_chan, .o_scan_result_count, .o_scan_temp_first, .o_scan_averaging, .o_chan_skip,
        .o_pair_twos_comp, .o_fifo_clear);
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        if (o_scan_start === 1'b1) n_scan++;
        if (o_fifo_clear === 1'b1) n_clr++;
    end
    task tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Ten cycles cover sync, decode and plan latency
    task send1(input logic [7:0] b);
        u_host.put_byte(b, 1'b1);
        tick(10);
    endtask
    task send2(input logic [7:0] a, input logic [7:0] b);
        u_host.put_byte(a, 1'b0);
        u_host.put_byte(b, 1'b1);
        tick(10);
    endtask
    // ------------------------------------------------
    // Scenarios
    // ------------------------------------------------
    task t_reset;
        check({o_setup_config, o_conversion_request}, 16'h2000);
        check({o_averaging_config, o_unipolar_pair}, 16'h0000);
        check({o_bipolar_pair, o_pair_twos_comp}, 16'h0000);
    endtask
    task t_pairs;
        send2(8'h62, 8'h06);
        check({o_setup_config, o_unipolar_pair}, 16'h6206);
        send2(8'h63, 8'h83);
        check({o_bipolar_pair, o_pair_twos_comp}, 16'h8381);
        // Byte after a setup with no pair address is a fresh command
        send2(8'h60, 8'h3B);
        check({o_averaging_config, o_unipolar_pair}, 16'h3B06);
        check({o_bipolar_pair, o_setup_config}, 16'h8360);
    endtask
    task t_repeat;
        int s;
        s = n_scan;
        send1(8'hAD);
        check(16'(n_scan - s), 16'h0001);
        check({8'h00, o_conversion_request}, 16'h00AD);
        check({o_scan_first_chan, o_scan_last_chan, 3'h0, o_scan_result_count}, 16'h5510);
        check({14'h0, o_scan_temp_first, o_scan_averaging}, 16'h0003);
    endtask
    task t_extclk;
        int s;
        s = n_scan;
        send2(8'h70, 8'h9E);
        check(16'(n_scan - s), 16'h0001);
        check({o_scan_first_chan, o_scan_last_chan, 3'h0, o_scan_result_count}, 16'h3301);
        check({14'h0, o_scan_temp_first, o_scan_averaging}, 16'h0000);
        check({14'h0, o_chan_skip[15:14]}, 16'h0000);
    endtask
    task t_pin;
        int s;
        s = n_scan;
        send2(8'h4C, 8'h90);
        check(16'(n_scan - s), 16'h0000);
        check({14'h0, o_chan_skip[15:14]}, 16'h0003);
        i_conv_start_n <= 1'b0;
        tick(4);
        i_conv_start_n <= 1'b1;
        tick(10);
        check(16'(n_scan - s), 16'h0001);
        // Bipolar pair 0/1 yields one result, channel 2 another
        check({o_scan_first_chan, o_scan_last_chan, 3'h0, o_scan_result_count}, 16'h0202);
    endtask
    task t_high;
        int s;
        s = n_scan;
        send2(8'h5C, 8'hE3);
        check(16'(n_scan - s), 16'h0000);
        i_conv_start_n <= 1'b0;
        tick(4);
        i_conv_start_n <= 1'b1;
        tick(10);
        check(16'(n_scan - s), 16'h0001);
        // Pair 12/13 counts once; reserved top pair is dropped
        check({o_scan_first_chan, o_scan_last_chan, 3'h0, o_scan_result_count}, 16'hCF01);
        check({14'h0, o_scan_temp_first, o_scan_averaging}, 16'h0003);
    endtask
    task t_reset_cmd;
        int s;
        s = n_clr;
        send1(8'h18);
        check(16'(n_clr - s), 16'h0001);
        check({o_setup_config, o_unipolar_pair}, 16'h5C06);
        send1(8'h10);
        check(16'(n_clr - s), 16'h0002);
        check({o_setup_config, o_unipolar_pair}, 16'h2000);
        check({o_averaging_config, o_bipolar_pair}, 16'h0000);
    endtask
    task complete_run;
        $display("Checks %0d, errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        i_rstn = 1'b0;
        i_conv_start_n = 1'b1;
        tick(20);
        i_rstn <= 1'b1;
        tick(5);
        t_reset;
        t_pairs;
        t_repeat;
        t_extclk;
        t_pin;
        t_high;
        t_reset_cmd;
        complete_run;
    end
    initial begin
        #2000000;
        n_errors++;
        complete_run;
    end
endmodule
`default_nettype wire

//--- rtl/ascd_decoder.v
// Serial command decoder of a multichannel converter: shifts in bytes,
// decodes the register prefixes and plans each requested scan.
// Assumes serial clock, chip select, data and start pin are asynchronous
// pins sampled by i_clk, which must run well above twice the serial clock.
`default_nettype none
`include "ascd_regs.vh"

module ascd_decoder (
    input wire i_clk,
    input wire i_rstn,
    input wire i_sclk,
    input wire i_cs_n,
    input wire i_din,
    input wire i_conv_start_n,
    output reg [7:0] o_conversion_request,
    output reg [7:0] o_setup_config,
    output reg [7:0] o_averaging_config,
    output reg [7:0] o_unipolar_pair,
    output reg [7:0] o_bipolar_pair,
    output reg o_scan_start,
    output reg [3:0] o_scan_first_chan,
    output reg [3:0] o_scan_last_chan,
    output reg [4:0] o_scan_result_count,
    output reg o_scan_temp_first,
    output reg o_scan_averaging,
    output reg [15:0] o_chan_skip,
    output reg [7:0] o_pair_twos_comp,
    output reg o_fifo_clear
);

// ----------------------------------------------------------------
// Pin sampling
// ----------------------------------------------------------------
wire sclk_s;
wire cs_n_s;
wire din_s;
wire cnv_n_s;
wire [`ASCD_PIN_CNT-1:0] pin_async = {i_conv_start_n, i_din, i_cs_n, i_sclk};
wire [`ASCD_PIN_CNT-1:0] pin_idle = `ASCD_PIN_IDLE;
wire [`ASCD_PIN_CNT-1:0] pin_sync;
reg sclk_d_reg;
reg cnv_d_reg;
genvar g;

generate
    for (g = 0; g < `ASCD_PIN_CNT; g = g + 1) begin : g_pin_sync
        ascd_sync u_sync (
            .i_clk(i_clk),
            .i_rstn(i_rstn),
            .i_async(pin_async[g]),
            .i_rst_val(pin_idle[g]),
            .o_sync(pin_sync[g])
        );
    end
endgenerate

assign sclk_s = pin_sync[0];
assign cs_n_s = pin_sync[1];
assign din_s = pin_sync[2];
assign cnv_n_s = pin_sync[3];

// Sync flops reset to each pin's idle level, so leaving reset shows
// no false start-pin fall and no select before the host drives one.
wire sclk_rise = sclk_s & ~sclk_d_reg;
wire cnv_fall = ~cnv_n_s & cnv_d_reg;

// ----------------------------------------------------------------
// Byte assembly
// ----------------------------------------------------------------
localparam ST_CMD = 2'b01;
localparam ST_PAIR = 2'b10;

reg [1:0] state_reg;
reg [1:0] state_next;
reg [6:0] shift_reg;
reg [2:0] bit_cnt_reg;
reg pair_bi_reg;
reg pair_bi_next;
wire [7:0] rx_byte = {shift_reg, din_s};
wire byte_done = sclk_rise & ~cs_n_s & (bit_cnt_reg == `ASCD_LAST_BIT);

always @(posedge i_clk) begin
    if (!i_rstn) begin
        sclk_d_reg <= 1'b0;
        cnv_d_reg <= 1'b1;
        shift_reg <= 7'h00;
        bit_cnt_reg <= 3'h0;
    end else begin
        sclk_d_reg <= sclk_s;
        cnv_d_reg <= cnv_n_s;
        if (cs_n_s) begin
            bit_cnt_reg <= 3'h0;
        end else if (sclk_rise) begin
            shift_reg <= rx_byte[6:0];
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
        end
    end
end

// ----------------------------------------------------------------
// Decode helpers
// ----------------------------------------------------------------
// True in the two clock modes where the start pin starts a scan
function ascd_pin_mode;
    input [1:0] ck;
    begin
        ascd_pin_mode = (ck == `ASCD_CK_PIN_INT) || (ck == `ASCD_CK_PIN_EXT);
    end
endfunction

function [15:0] ascd_reserved;
    input [7:0] setup;
    input [7:0] uni;
    input [7:0] bi;
    reg [15:0] m;
    begin
        m = 16'h0000;
        if (ascd_pin_mode(setup[`ASCD_SETUP_CK_HI:`ASCD_SETUP_CK_LO])) begin
            m[`ASCD_CONVERSION_START_PIN_CH] = 1'b1;
        end
        if (setup[`ASCD_SETUP_REF_HI:`ASCD_SETUP_REF_LO] == `ASCD_REF_EXT_DIFF) begin
            m[`ASCD_REFN_CH] = 1'b1;
        end
        if ((uni[0] | bi[0]) && (m[`ASCD_CONVERSION_START_PIN_CH] | m[`ASCD_REFN_CH])) begin
            m[`ASCD_CONVERSION_START_PIN_CH] = 1'b1;
            m[`ASCD_REFN_CH] = 1'b1;
        end
        ascd_reserved = m;
    end
endfunction

function [4:0] ascd_range_count;
    input [3:0] first;
    input [3:0] last;
    input [15:0] skip;
    input [7:0] pairs;
    integer k;
    reg [4:0] n;
    begin
        n = 5'h00;
        // Pair counts once at its lower channel; odd member adds none
        for (k = 0; k < 16; k = k + 1) begin
            if (k >= first && k <= last && !skip[k]) begin
                if (!(pairs[7 - k / 2] && (k % 2 == 1))) begin
                    n = n + `ASCD_CNT_ONE;
                end
            end
        end
        ascd_range_count = n;
    end
endfunction

// ----------------------------------------------------------------
// Registers and scan planning
// ----------------------------------------------------------------
wire [15:0] skip_now = ascd_reserved(o_setup_config, o_unipolar_pair, o_bipolar_pair);
wire [7:0] pairs_now = o_unipolar_pair | o_bipolar_pair;
wire [1:0] ck_mode = o_setup_config[`ASCD_SETUP_CK_HI:`ASCD_SETUP_CK_LO];
wire [3:0] req_chan = o_conversion_request[`ASCD_CONV_CH_HI:`ASCD_CONV_CH_LO];
wire [1:0] req_scan = o_conversion_request[`ASCD_CONV_SCAN_HI:`ASCD_CONV_SCAN_LO];
wire [1:0] rpt_sel = o_averaging_config[`ASCD_AVG_RPT_HI:`ASCD_AVG_RPT_LO];
reg plan_pending_reg;
reg [3:0] first_c;
reg [3:0] last_c;
reg [4:0] count_c;

always @* begin
    first_c = req_chan;
    last_c = req_chan;
    case (req_scan)
        `ASCD_SCAN_LOW_TO_N: begin
            first_c = `ASCD_CHAN_ZERO;
        end
        `ASCD_SCAN_N_TO_TOP: begin
            last_c = `ASCD_CHAN_MAX;
        end
        default: begin
        end
    endcase
    if (req_scan == `ASCD_SCAN_REPEAT) begin
        if (skip_now[req_chan]) begin
            count_c = 5'h00;
        end else if (rpt_sel == 2'h0) begin
            count_c = `ASCD_RPT_0;
        end else if (rpt_sel == 2'h1) begin
            count_c = `ASCD_RPT_1;
        end else if (rpt_sel == 2'h2) begin
            count_c = `ASCD_RPT_2;
        end else begin
            count_c = `ASCD_RPT_3;
        end
    end else if (req_scan == `ASCD_SCAN_SINGLE) begin
        count_c = skip_now[req_chan] ? 5'h00 : `ASCD_CNT_ONE;
    end else begin
        count_c = ascd_range_count(first_c, last_c, skip_now, pairs_now);
    end
end

wire is_conv = rx_byte[`ASCD_CONV_FLAG];
wire is_setup = ~is_conv & rx_byte[`ASCD_SETUP_FLAG];
wire is_avg = ~is_conv & ~rx_byte[`ASCD_SETUP_FLAG] & rx_byte[`ASCD_AVG_FLAG];
wire is_rst = (rx_byte[`ASCD_CONV_FLAG:`ASCD_AVG_FLAG] == 3'h0) & rx_byte[`ASCD_RST_FLAG];

always @* begin
    state_next = state_reg;
    pair_bi_next = pair_bi_reg;
    case (state_reg)
        ST_CMD: begin
            if (byte_done && is_setup && rx_byte[`ASCD_SETUP_DIFF_HI]) begin
                state_next = ST_PAIR;
                pair_bi_next = rx_byte[`ASCD_SETUP_DIFF_LO];
            end
        end
        ST_PAIR: begin
            // A raised select drops a half-sent pair byte
            if (byte_done || cs_n_s) begin
                state_next = ST_CMD;
            end
        end
        default: begin
            state_next = ST_CMD;
        end
    endcase
end

always @(posedge i_clk) begin
    if (!i_rstn) begin
        state_reg <= ST_CMD;
        pair_bi_reg <= 1'b0;
        o_conversion_request <= `ASCD_ZERO_BYTE;
        o_setup_config <= `ASCD_SETUP_RESET;
        o_averaging_config <= `ASCD_ZERO_BYTE;
        o_unipolar_pair <= `ASCD_ZERO_BYTE;
        o_bipolar_pair <= `ASCD_ZERO_BYTE;
        o_fifo_clear <= 1'b0;
        plan_pending_reg <= 1'b0;
        o_scan_start <= 1'b0;
        o_scan_first_chan <= `ASCD_CHAN_ZERO;
        o_scan_last_chan <= `ASCD_CHAN_ZERO;
        o_scan_result_count <= 5'h00;
        o_scan_temp_first <= 1'b0;
        o_scan_averaging <= 1'b0;
        o_chan_skip <= 16'h0000;
        o_pair_twos_comp <= `ASCD_ZERO_BYTE;
    end else begin
        state_reg <= state_next;
        pair_bi_reg <= pair_bi_next;
        o_fifo_clear <= 1'b0;
        o_scan_start <= 1'b0;
        plan_pending_reg <= 1'b0;
        o_chan_skip <= skip_now;
        o_pair_twos_comp <= o_bipolar_pair & ~o_unipolar_pair;
        // Pair byte first: it carries no prefix of its own
        if (state_reg == ST_PAIR && byte_done) begin
            if (pair_bi_reg) begin
                o_bipolar_pair <= rx_byte;
            end else begin
                o_unipolar_pair <= rx_byte;
            end
        end else if (byte_done && is_conv) begin
            o_conversion_request <= rx_byte;
            if (ck_mode == `ASCD_CK_SERIAL || ck_mode == `ASCD_CK_EXTCLK) begin
                plan_pending_reg <= 1'b1;
            end
        end else if (byte_done && is_setup) begin
            o_setup_config <= rx_byte;
        end else if (byte_done && is_avg) begin
            o_averaging_config <= rx_byte;
        end else if (byte_done && is_rst) begin
            if (rx_byte[`ASCD_RST_FIFO_ONLY]) begin
                o_fifo_clear <= 1'b1;
            end else begin
                o_conversion_request <= `ASCD_ZERO_BYTE;
                o_setup_config <= `ASCD_SETUP_RESET;
                o_averaging_config <= `ASCD_ZERO_BYTE;
                o_unipolar_pair <= `ASCD_ZERO_BYTE;
                o_bipolar_pair <= `ASCD_ZERO_BYTE;
                o_fifo_clear <= 1'b1;
            end
        end
        // Pin start only in the two pin-driven clock modes
        if (cnv_fall && ascd_pin_mode(ck_mode)) begin
            plan_pending_reg <= 1'b1;
        end
        // Plan one cycle after the request so it sees the new byte
        if (plan_pending_reg) begin
            o_scan_start <= 1'b1;
            o_scan_first_chan <= first_c;
            o_scan_last_chan <= last_c;
            o_scan_result_count <= count_c;
            o_scan_temp_first <= o_conversion_request[`ASCD_CONV_TEMP];
            o_scan_averaging <= o_averaging_config[`ASCD_AVG_EN] & (ck_mode != `ASCD_CK_EXTCLK);
        end
    end
end

endmodule

`default_nettype wire

//--- rtl/ascd_regs.vh
// Constants for the serial command decoder: byte layouts, reset values, modes.
// Assumes inclusion by the decoder files only; definitions only.
`ifndef ASCD_REGS_VH
`define ASCD_REGS_VH

`define ASCD_BYTE_W 8
`define ASCD_BIT_CNT_W 3
`define ASCD_LAST_BIT 3'h7
`define ASCD_CHAN_W 4
`define ASCD_CHAN_MAX 4'hF
`define ASCD_CHAN_ZERO 4'h0
`define ASCD_CNT_W 5
`define ASCD_CNT_ONE 5'h01

// Prefix positions
`define ASCD_CONV_FLAG 7
`define ASCD_SETUP_FLAG 6
`define ASCD_AVG_FLAG 5
`define ASCD_RST_FLAG 4

// Conversion byte fields
`define ASCD_CONV_CH_HI 6
`define ASCD_CONV_CH_LO 3
`define ASCD_CONV_SCAN_HI 2
`define ASCD_CONV_SCAN_LO 1
`define ASCD_CONV_TEMP 0

// Setup byte fields
`define ASCD_SETUP_CK_HI 5
`define ASCD_SETUP_CK_LO 4
`define ASCD_SETUP_REF_HI 3
`define ASCD_SETUP_REF_LO 2
`define ASCD_SETUP_DIFF_HI 1
`define ASCD_SETUP_DIFF_LO 0

// Averaging byte fields
`define ASCD_AVG_EN 4
`define ASCD_AVG_N_HI 3
`define ASCD_AVG_N_LO 2
`define ASCD_AVG_RPT_HI 1
`define ASCD_AVG_RPT_LO 0

// Reset byte field
`define ASCD_RST_FIFO_ONLY 3

// Reset values
`define ASCD_ZERO_BYTE 8'h00
`define ASCD_SETUP_RESET 8'h20

// Scan modes
`define ASCD_SCAN_LOW_TO_N 2'h0
`define ASCD_SCAN_N_TO_TOP 2'h1
`define ASCD_SCAN_REPEAT 2'h2
`define ASCD_SCAN_SINGLE 2'h3

// Clock modes
`define ASCD_CK_PIN_INT 2'h0
`define ASCD_CK_PIN_EXT 2'h1
`define ASCD_CK_SERIAL 2'h2
`define ASCD_CK_EXTCLK 2'h3

// Pair register addressing
`define ASCD_DIFF_UNI 2'h2
`define ASCD_DIFF_BI 2'h3

// Reference mode that reserves the negative reference channel
`define ASCD_REF_EXT_DIFF 2'h3

// Repeat counts for 00..11 of the repeat field
`define ASCD_RPT_0 5'h04
`define ASCD_RPT_1 5'h08
`define ASCD_RPT_2 5'h0C
`define ASCD_RPT_3 5'h10

// Multi-purpose channels on the sixteen-input build
`define ASCD_CONVERSION_START_PIN_CH 4'hF
`define ASCD_REFN_CH 4'hE

// Pin synchronisers: bit 3 start pin, 2 data, 1 select, 0 serial clock
`define ASCD_PIN_CNT 4
`define ASCD_PIN_IDLE 4'hA

`endif

//--- rtl/ascd_sync.v
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes a single clock; the first stage is read only by the second.
`default_nettype none

module ascd_sync (
    input wire i_clk,
    input wire i_rstn,
    input wire i_async,
    input wire i_rst_val,
    output reg o_sync
);

reg meta_reg;

always @(posedge i_clk) begin
    if (!i_rstn) begin
        meta_reg <= i_rst_val;
        o_sync <= i_rst_val;
    end else begin
        meta_reg <= i_async;
        o_sync <= meta_reg;
    end
end

endmodule

`default_nettype wire
